// ==== hw/ced_pkg.sv ====
// shared types and constants of the can error detection block
package ced_pkg;

	// frame field in which the current bit lies, one-hot
	typedef enum logic [9:0] {
		CED_FLD_IDLE = 10'b00_0000_0001,
		CED_FLD_SOF = 10'b00_0000_0010,
		CED_FLD_ARB = 10'b00_0000_0100,
		CED_FLD_CTRL = 10'b00_0000_1000,
		CED_FLD_DATA = 10'b00_0001_0000,
		CED_FLD_CRC = 10'b00_0010_0000,
		CED_FLD_CRC_DELIM = 10'b00_0100_0000,
		CED_FLD_ACK_SLOT = 10'b00_1000_0000,
		CED_FLD_ACK_DELIM = 10'b01_0000_0000,
		CED_FLD_EOF = 10'b10_0000_0000
	} ced_field_t;

	// sticky error classes
	typedef struct packed {
		logic bit_err;
		logic stuff_err;
		logic form_err;
		logic crc_err;
		logic ack_err;
	} ced_err_t;

	// one bit offered by the frame builder
	typedef struct packed {
		ced_field_t field;
		logic tx_active;
		logic tx_bit;
	} ced_bit_req_t;

	// bus levels: dominant is low
	localparam logic CED_DOMINANT = 1'b0;
	localparam logic CED_RECESSIVE = 1'b1;

	// bit stuffing run length
	localparam logic [2:0] CED_STUFF_RUN = 3'h5;

	// crc-15 generator and register width
	localparam int CED_CRC_W = 15;
	localparam logic [14:0] CED_CRC_POLY = 15'h4599;
	localparam logic [14:0] CED_CRC_INIT = 15'h0000;

	localparam ced_err_t CED_ERR_NONE = '0;

endpackage

// ==== hw/ced_error_detect.sv ====
// can bit stuffing, crc and bus error detection for one controller
`timescale 1ns/100ps

// Behaviour
// - in stuffed fields, after five equal sent bits, send one opposite bit
// - flag stuff error on a sixth equal bit inside a stuffed field
// - if enabled, flag and interrupt when sampled bit differs from sent
// - compute crc over outgoing frame and send it in the crc field
// - recompute crc on received frame; flag crc error on mismatch
// - a node that received a frame correctly drives dominant in ack slot
// - transmitter flags acknowledge error when ack slot stays recessive
// - flag form error on a dominant bit in a fixed recessive field
module ced_error_detect (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic bit_start_i,
	input wire logic bit_sample_i,
	input wire ced_pkg::ced_bit_req_t bit_req_i,
	input wire logic bit_err_en_i,
	input wire ced_pkg::ced_err_t err_clr_i,
	input wire logic can_rx_i,
	output logic can_tx_o,
	output logic bit_done_o,
	output logic rx_bit_o,
	output ced_pkg::ced_err_t err_flags_o,
	output logic bit_err_irq_o
);

	// reset release through two flip-flops
	logic rst_m;
	logic rst_b;
	always_ff @(posedge mclk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rst_m <= 1'b0;
			rst_b <= 1'b0;
		end else begin
			rst_m <= 1'b1;
			rst_b <= rst_m;
		end
	end

	// bus input: three flops, level taken once second and third agree
	logic rx_s1;
	logic rx_s2;
	logic rx_s3;
	logic rx_lvl;
	always_ff @(posedge mclk_i or negedge rst_b) begin
		if (!rst_b) begin
			rx_s1 <= ced_pkg::CED_RECESSIVE;
			rx_s2 <= ced_pkg::CED_RECESSIVE;
			rx_s3 <= ced_pkg::CED_RECESSIVE;
			rx_lvl <= ced_pkg::CED_RECESSIVE;
		end else begin
			rx_s1 <= can_rx_i;
			rx_s2 <= rx_s1;
			rx_s3 <= rx_s2;
			if (rx_s2 == rx_s3) begin
				rx_lvl <= rx_s3;
			end
		end
	end

	// crc-15 step for one bit
	function automatic logic [14:0] crc_step(input logic [14:0] crc,
			input logic din);
		logic fb;
		fb = din ^ crc[14];
		crc_step = {crc[13:0], 1'b0} ^ (fb ? ced_pkg::CED_CRC_POLY : 15'h0000);
	endfunction

	// run length after one more bit, saturating past the stuff length
	function automatic logic [2:0] run_step(input logic [2:0] cnt,
			input logic last, input logic din);
		if (cnt != 3'h0 && din == last) begin
			run_step = (cnt == 3'h7) ? cnt : cnt + 3'h1;
		end else begin
			run_step = 3'h1;
		end
	endfunction

	ced_pkg::ced_field_t fld;
	logic stuffed_fld;
	logic crc_fld;
	logic fixed_fld;
	assign fld = bit_req_i.field;
	// sof through crc sequence carry stuff bits
	assign stuffed_fld = (fld == ced_pkg::CED_FLD_SOF) ||
		(fld == ced_pkg::CED_FLD_ARB) || (fld == ced_pkg::CED_FLD_CTRL) ||
		(fld == ced_pkg::CED_FLD_DATA) || (fld == ced_pkg::CED_FLD_CRC);
	assign crc_fld = (fld == ced_pkg::CED_FLD_CRC);
	// fields whose every bit must be recessive
	assign fixed_fld = (fld == ced_pkg::CED_FLD_CRC_DELIM) ||
		(fld == ced_pkg::CED_FLD_ACK_DELIM) || (fld == ced_pkg::CED_FLD_EOF);

	logic [14:0] crc;
	logic [2:0] tx_run;
	logic tx_last;
	logic [2:0] rx_run;
	logic rx_last;
	logic crc_ok;
	logic tx_stuff;
	logic rx_stuff;
	logic next_tx;

	// bit to drive at bit start: stuff bit, crc bit, ack or frame bit
	always_comb begin
		tx_stuff = 1'b0;
		next_tx = ced_pkg::CED_RECESSIVE;
		if (bit_req_i.tx_active && stuffed_fld &&
				tx_run == ced_pkg::CED_STUFF_RUN) begin
			tx_stuff = 1'b1;
			next_tx = ~tx_last;
		end else if (bit_req_i.tx_active && crc_fld) begin
			next_tx = crc[14];
		end else if (bit_req_i.tx_active && fixed_fld) begin
			// a builder slip must not put dominant into a delimiter
			next_tx = ced_pkg::CED_RECESSIVE;
		end else if (bit_req_i.tx_active) begin
			next_tx = bit_req_i.tx_bit;
		end else if (fld == ced_pkg::CED_FLD_ACK_SLOT && crc_ok) begin
			next_tx = ced_pkg::CED_DOMINANT;
		end
	end

	// bus driver, changed only at the start of a bit
	logic driving_stuff;
	always_ff @(posedge mclk_i or negedge rst_b) begin
		if (!rst_b) begin
			can_tx_o <= ced_pkg::CED_RECESSIVE;
			driving_stuff <= 1'b0;
		end else if (bit_start_i) begin
			can_tx_o <= next_tx;
			driving_stuff <= tx_stuff;
		end
	end

	// transmit run length over driven bits; idle restarts it
	always_ff @(posedge mclk_i or negedge rst_b) begin
		if (!rst_b) begin
			tx_run <= 3'h0;
			tx_last <= ced_pkg::CED_RECESSIVE;
		end else if (fld == ced_pkg::CED_FLD_IDLE || !stuffed_fld) begin
			tx_run <= 3'h0;
		end else if (bit_start_i && bit_req_i.tx_active) begin
			tx_run <= run_step(tx_run, tx_last, next_tx);
			tx_last <= next_tx;
		end
	end

	// receive side: after five equal bits the next one is a stuff bit
	assign rx_stuff = stuffed_fld && rx_run == ced_pkg::CED_STUFF_RUN;

	always_ff @(posedge mclk_i or negedge rst_b) begin
		if (!rst_b) begin
			rx_run <= 3'h0;
			rx_last <= ced_pkg::CED_RECESSIVE;
		end else if (fld == ced_pkg::CED_FLD_IDLE || !stuffed_fld) begin
			rx_run <= 3'h0;
		end else if (bit_sample_i) begin
			rx_run <= run_step(rx_run, rx_last, rx_lvl);
			rx_last <= rx_lvl;
		end
	end

	// destuffed bit handed back to the frame builder
	always_ff @(posedge mclk_i or negedge rst_b) begin
		if (!rst_b) begin
			bit_done_o <= 1'b0;
			rx_bit_o <= ced_pkg::CED_RECESSIVE;
		end else begin
			bit_done_o <= bit_sample_i && !rx_stuff;
			if (bit_sample_i) begin
				rx_bit_o <= rx_lvl;
			end
		end
	end

	// running crc over sof..data, then over the received crc sequence;
	// a clean frame leaves zero, so one register serves both ends
	always_ff @(posedge mclk_i or negedge rst_b) begin
		if (!rst_b) begin
			crc <= ced_pkg::CED_CRC_INIT;
		end else if (fld == ced_pkg::CED_FLD_IDLE) begin
			crc <= ced_pkg::CED_CRC_INIT;
		end else if (bit_sample_i && stuffed_fld && !rx_stuff) begin
			crc <= crc_step(crc, rx_lvl);
		end
	end

	// frame check result, held for the ack slot
	always_ff @(posedge mclk_i or negedge rst_b) begin
		if (!rst_b) begin
			crc_ok <= 1'b0;
		end else if (fld == ced_pkg::CED_FLD_IDLE) begin
			crc_ok <= 1'b0;
		end else if (bit_sample_i && fld == ced_pkg::CED_FLD_CRC_DELIM) begin
			crc_ok <= (crc == ced_pkg::CED_CRC_INIT) && !err_flags_o.stuff_err;
		end
	end

	// error events at the sample point
	ced_pkg::ced_err_t err_set;
	always_comb begin
		err_set = ced_pkg::CED_ERR_NONE;
		if (bit_sample_i) begin
			// losing arbitration and the ack slot are not bit errors
			err_set.bit_err = bit_err_en_i && bit_req_i.tx_active &&
				rx_lvl != can_tx_o && fld != ced_pkg::CED_FLD_ACK_SLOT &&
				!(fld == ced_pkg::CED_FLD_ARB && !driving_stuff &&
				can_tx_o == ced_pkg::CED_RECESSIVE);
			err_set.stuff_err = rx_stuff && rx_lvl == rx_last;
			err_set.form_err = fixed_fld &&
				rx_lvl == ced_pkg::CED_DOMINANT;
			err_set.crc_err = fld == ced_pkg::CED_FLD_CRC_DELIM &&
				crc != ced_pkg::CED_CRC_INIT;
			err_set.ack_err = bit_req_i.tx_active &&
				fld == ced_pkg::CED_FLD_ACK_SLOT &&
				rx_lvl == ced_pkg::CED_RECESSIVE;
		end
	end

	// sticky flags; a new event wins over a clear in the same cycle
	always_ff @(posedge mclk_i or negedge rst_b) begin
		if (!rst_b) begin
			err_flags_o <= ced_pkg::CED_ERR_NONE;
		end else begin
			err_flags_o <= err_set | (err_flags_o & ~err_clr_i);
		end
	end

	// interrupt request follows the sticky bit error flag
	assign bit_err_irq_o = err_flags_o.bit_err;

endmodule // ced_error_detect

// ==== bench/ced_error_detect_asserts.sv ====
// port assertions for the can error detection block
`timescale 1ns/100ps
module ced_error_detect_asserts (
	input wire logic mclk_i,
	input wire logic rst_b_i,
	input wire logic bit_start_i,
	input wire logic bit_sample_i,
	input wire ced_pkg::ced_bit_req_t bit_req_i,
	input wire logic bit_err_en_i,
	input wire ced_pkg::ced_err_t err_clr_i,
	input wire logic can_tx_o,
	input wire logic bit_done_o,
	input wire ced_pkg::ced_err_t err_flags_o,
	input wire logic bit_err_irq_o
);
	localparam logic [9:0] FIX = ced_pkg::CED_FLD_CRC_DELIM |
		ced_pkg::CED_FLD_ACK_DELIM | ced_pkg::CED_FLD_EOF;
	logic ack_q;
	logic fix_q;
	default clocking @(posedge mclk_i); endclocking
	default disable iff (!rst_b_i);
	// field of the last sample point, since flags land one cycle later
	always_ff @(posedge mclk_i) begin
		ack_q <= bit_sample_i && bit_req_i.tx_active &&
			bit_req_i.field == ced_pkg::CED_FLD_ACK_SLOT;
		fix_q <= bit_sample_i && |(bit_req_i.field & FIX);
	end
	sequence s_fix_start;
		bit_start_i && bit_req_i.tx_active && |(bit_req_i.field & FIX);
	endsequence
	AST_IRQ_LEVEL: assert property (bit_err_irq_o == err_flags_o.bit_err)
		else $error("irq differs from bit error flag");
	AST_FLAG_STICKY: assert property (1 |=>
		($past(err_flags_o) & ~$past(err_clr_i) & ~err_flags_o) == '0)
		else $error("flag dropped without clear");
	AST_TX_HOLD: assert property (!bit_start_i |=> $stable(can_tx_o))
		else $error("tx changed outside bit start");
	AST_FLAG_CAUSE: assert property (
		(err_flags_o & ~$past(err_flags_o)) != '0 |-> $past(bit_sample_i))
		else $error("flag set without sample point");
	AST_ACK_CAUSE: assert property ($rose(err_flags_o.ack_err) |-> ack_q)
		else $error("ack error outside own ack slot");
	AST_FORM_CAUSE: assert property ($rose(err_flags_o.form_err) |-> fix_q)
		else $error("form error outside fixed field");
	AST_BIT_EN: assert property (
		$rose(err_flags_o.bit_err) |-> $past(bit_err_en_i))
		else $error("bit error while check disabled");
	AST_TX_FIX: assert property (s_fix_start |=> can_tx_o)
		else $error("dominant sent in fixed field");
	AST_DONE_CAUSE: assert property (
		bit_done_o |-> $past(bit_sample_i))
		else $error("bit handed over without sample point");
endmodule // ced_error_detect_asserts
bind ced_error_detect ced_error_detect_asserts u_chk (.mclk_i, .rst_b_i,
	.bit_start_i, .bit_sample_i, .bit_req_i, .bit_err_en_i, .err_clr_i,
	.can_tx_o, .bit_done_o, .err_flags_o, .bit_err_irq_o);

// ==== bench/ced_bus_node.sv ====
// the other bus nodes, merged into one wired-and partner
`timescale 1ns/100ps
module ced_bus_node (
	input wire logic tx_i,
	input wire logic dom_i,
	output logic bus_o
);
	// dominant wins; dom_i is an acknowledge or a forced dominant bit
	assign bus_o = tx_i & ~dom_i;
endmodule // ced_bus_node

// ==== bench/tb_can_error_detection.sv ====
// self-checking bench for the can error detection block
`timescale 1ns/100ps
module tb_can_error_detection;
	logic mclk_i, rst_b_i, bs, sp, en, dom, rx, tx, done, irq, t0, tl, rxb;
	logic [14:0] c;
	int stf, fail_count, compares, cyc;
	ced_pkg::ced_bit_req_t req;
	ced_pkg::ced_err_t clr, flg;
	ced_error_detect dut (.mclk_i, .rst_b_i, .bit_start_i(bs),
		.bit_sample_i(sp), .bit_req_i(req), .bit_err_en_i(en),
		.err_clr_i(clr), .can_rx_i(rx), .can_tx_o(tx), .bit_done_o(done),
		.rx_bit_o(rxb), .err_flags_o(flg), .bit_err_irq_o(irq));
	ced_bus_node node (.tx_i(tx), .dom_i(dom), .bus_o(rx));
	initial begin
		mclk_i = 0;
		forever #10 mclk_i = ~mclk_i;
	end
	// a hang ends the run as a failure
	always @(posedge mclk_i) begin
		cyc++;
		if (cyc == 3000) begin
			fail_count++;
			report_and_stop();
		end
	end
	task automatic chk(input logic [14:0] s, input logic [14:0] e);
		compares++;
		if (s !== e) begin
			fail_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, s, e);
		end
	endtask
	// one bit; f is the one-hot field index; stuff bits repeat the request
	task automatic bt(input int f, input logic a, b, d);
		stf = -1;
		do begin
			@(negedge mclk_i);
			req = {10'h001 << f, a, b};
			bs = 1;
			dom = d;
			@(negedge mclk_i);
			bs = 0;
			if (stf < 0) t0 = tx;
			tl = tx;
			repeat (6) @(negedge mclk_i);
			sp = 1;
			@(negedge mclk_i);
			sp = 0;
			stf++;
		end while (done !== 1'b1 && stf < 3);
	endtask
	task automatic clear;
		clr = '1;
		@(negedge mclk_i);
		clr = '0;
		@(negedge mclk_i);
		chk(flg, 0);
	endtask
	task automatic sc_stuff;
		bt(0, 0, 1, 0);
		bt(1, 1, 0, 0);
		repeat (4) bt(2, 1, 0, 0);
		chk(15'(stf), 15'h0000);
		bt(2, 1, 0, 0);
		chk({t0, tl, 4'(stf)}, 6'h21);
		bt(0, 0, 1, 0);
		bt(1, 0, 1, 1);
		repeat (5) bt(2, 0, 1, 1);
		chk(flg, 5'h08);
		repeat (40) @(negedge mclk_i);
		chk(flg, 5'h08);
		clear();
	endtask
	task automatic sc_bus;
		en = 1;
		bt(0, 0, 1, 0);
		bt(1, 1, 0, 0);
		bt(4, 1, 1, 1);
		chk({irq, flg}, 6'h30);
		clear();
		en = 0;
		bt(4, 1, 1, 1);
		chk(flg, 0);
		bt(7, 1, 1, 0);
		chk(flg, 5'h01);
		clear();
		bt(7, 1, 1, 1);
		chk(flg, 0);
		bt(9, 0, 1, 1);
		chk(flg, 5'h04);
		clear();
		bt(9, 1, 0, 0);
		chk({tl, flg}, 6'h20);
	endtask
	// received crc is the true one (pattern kept stuff free) or 0101...,
	// which needs no stuffing either; a mismatch is expected unless the true crc is 2aaa
	task automatic sc_crc(input logic a, input logic [4:0] pat,
			input logic g);
		logic b;
		logic e;
		c = ced_pkg::CED_CRC_INIT;
		bt(0, 0, 1, 0);
		for (int i = 4; i >= 0; i--) begin
			b = pat[i];
			bt(i == 4 ? 1 : 4, a, b, !b);
			chk(rxb, b);
			c = {c[13:0], 1'b0} ^ ((b ^ c[14]) ? ced_pkg::CED_CRC_POLY : '0);
		end
		for (int i = 14; i >= 0; i--) begin
			b = g ? c[i] : i[0];
			bt(5, a, b, !a && !b);
			if (a) chk(tl, c[i]);
		end
		e = !a && !g && c !== 15'h2aaa;
		bt(6, a, 1, 0);
		chk(flg.crc_err, e);
		// own frame: the partner acks; received frame: we ack if it was clean
		bt(7, a, 1, a);
		chk(tl, a || e);
		chk(flg, {3'h0, e, 1'b0});
		clear();
	endtask
	task automatic report_and_stop;
		$display("fail_count=%0d compares=%0d", fail_count, compares);
		if (fail_count == 0 && compares > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	initial begin
		rst_b_i = 0;
		bs = 0;
		sp = 0;
		en = 0;
		dom = 0;
		req = {ced_pkg::CED_FLD_IDLE, 1'b0, 1'b1};
		clr = '0;
		repeat (12) @(negedge mclk_i);
		rst_b_i = 1;
		repeat (4) @(negedge mclk_i);
		sc_stuff();
		sc_bus();
		sc_crc(1'b1, 5'h0b, 1'b0);
		sc_crc(1'b0, 5'h0b, 1'b0);
		sc_crc(1'b0, 5'h0a, 1'b1);
		report_and_stop();
	end
endmodule // tb_can_error_detection
